// ==== rdbm_engine.sv ====
// Contract
// - Table holds 128 four-word blocks, four quadrants of 32.
// - Table base resets to word address 0x0400, taken from base register.
// - Word one is the control word selecting interrupts, busy and buffer type.
// - Control word gets accessed and broadcast-received flags for polling.
// - Busy answer comes from the control word of the subaddress.
// - Simplified mode processing keeps info, time tag and data in the block.
// - Mode command interrupts are enabled by its own control word.
// - Host selects active table by writing the base register.
// - Index mode words: control, primary pointer, index count, broadcast pointer.
// - Index message buffer is 34 words: info, time tag, 32 data.
// - Broadcast data uses broadcast pointer when the host allocated one.
// - Good message off the primary pointer decrements nonzero count; nonzero result advances pointer.
// - Count reaching or at zero keeps pointer; reaching zero raises enabled event.
// - Ping-pong words: control, buffer A, buffer B, broadcast pointer.
// - Ping-pong toggles the select bit after each good non-broadcast message.
// - Ping-pong broadcasts use the single broadcast buffer when its pointer is nonzero.
// - Options stop toggling on busy or illegal messages.
// - Ping-pong stores info and data together in the buffer.
// - Circular 2 words: control, start, current, info buffer address.
// - Info address counts messages; full when N zero bits become ones.
// - Circular 2 raises enabled event when the message count is done.
// - Circular 1 stores together and completes on a full buffer.
// - Mode block: control, info, time tag, data; data only codes 16-31.
`timescale 1ns/1ps
`include "rdbm_cfg.svh"
module rdbm_engine #(
  parameter int MAX_WORDS = 32
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                cmd_valid_i,
  input  rdbm_pkg::rdbm_cmd_t      cmd_i,
  output logic                     desc_ready_o,
  output logic                     busy_o,
  output logic                     word_ready_o,
  input  wire logic                rx_valid_i,
  input  wire logic [15:0]         rx_word_i,
  input  wire logic                tx_req_i,
  output logic                     tx_valid_o,
  output logic      [15:0]         tx_word_o,
  input  wire logic                end_valid_i,
  input  rdbm_pkg::rdbm_end_t      end_i,
  output logic                     done_o,
  output rdbm_pkg::rdbm_mem_t      mem_o,
  input  wire logic                mem_ack_i,
  input  wire logic [15:0]         mem_rdata_i,
  output rdbm_pkg::rdbm_evt_t      evt_o
);

  generate
    if (MAX_WORDS < 1 || MAX_WORDS > 32) begin : g_chk
      $error("MAX_WORDS must be 1 to 32");
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [1:0] reg_sel(input logic [7:0] adr);
    if (adr[1:0] != 2'b00 || adr[7:2] > `RDBM_REG_STAT) reg_sel = 2'd3;
    else reg_sel = adr[3:2];
  endfunction

  rdbm_pkg::rdbm_state_t   state;
  rdbm_pkg::rdbm_cmd_t     cmd;
  rdbm_pkg::rdbm_end_t     endr;
  rdbm_pkg::rdbm_bufmode_t bmode;
  logic [15:0] tbl_base;
  logic [2:0]  cfg_r;
  logic [15:0] desc, cw, w2, w3, w4, dptr, info, rxw;
  logic [15:0] next_desc, data_a, info_a, bufa, mask, nw2, nw3, nw4, ncw;
  logic [15:0] st_addr, st_wd;
  logic [5:0]  wcnt;
  logic        simplified_mode_processing_msg, use_bc, store_ok, c1_full, c2_full, toggle;
  logic        upd2, upd3, upd4, ixz, cdone, st_mem, st_we, st_skip;
  logic        wb_req;

  ////////////////////////////////////////////////////////////////////////
  // Register slave
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      tbl_base <= `RDBM_TBL_BASE_RST;
      cfg_r    <= 3'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        if (reg_sel(wb_adr_i) == 2'd0) begin
          if (wb_sel_i[0]) tbl_base[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) tbl_base[15:8] <= wb_dat_i[15:8];
        end
        if (reg_sel(wb_adr_i) == 2'd1 && wb_sel_i[0]) cfg_r <= wb_dat_i[2:0];
      end
      if (wb_req) begin
        case (reg_sel(wb_adr_i))
          2'd0:    wb_dat_o <= {16'h0000, tbl_base};
          2'd1:    wb_dat_o <= {29'h0, cfg_r};
          2'd2:    wb_dat_o <= {desc, 15'h0000, state != rdbm_pkg::S_IDLE};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Base is latched per message, so a host switch never splits a message
  // base write
  a_base_write: assert property ((wb_req && wb_we_i && reg_sel(wb_adr_i) == 2'd0 && wb_sel_i[1:0] == 2'b11)
    |=> tbl_base == $past(wb_dat_i[15:0])) else $error("base register write lost");

  ////////////////////////////////////////////////////////////////////////
  // Descriptor decode
  // block index
  assign next_desc = tbl_base + {7'h00, cmd_i.mode_cmd, cmd_i.tx, cmd_i.sa, 2'b00};

  always_comb begin
    bmode    = rdbm_pkg::rdbm_bufmode_t'(cw[`RDBM_CW_MODE_HI:`RDBM_CW_MODE_LO]);
    simplified_mode_processing_msg = cmd.mode_cmd & cfg_r[`RDBM_CFG_SIMPLIFIED_MODE_PROCESSING];
    use_bc   = cmd.bcast && w4 != 16'h0000 && (bmode == rdbm_pkg::BM_INDEX || bmode == rdbm_pkg::BM_PINGPONG);
    bufa     = use_bc ? w4 : ((bmode == rdbm_pkg::BM_PINGPONG && cw[`RDBM_CW_PPSEL]) ? w3 : w2);
    if (simplified_mode_processing_msg) begin
      info_a = desc + 16'h0001;
      data_a = desc + 16'h0003;
    end else if (bmode == rdbm_pkg::BM_CIRC2) begin
      info_a = w4;
      data_a = w3;
    end else if (bmode == rdbm_pkg::BM_CIRC1) begin
      info_a = w3;
      data_a = w3 + `RDBM_HDR_WORDS;
    end else begin
      info_a = bufa;
      data_a = bufa + `RDBM_HDR_WORDS;
    end
  end

  assign store_ok = wcnt < 6'(MAX_WORDS) &&
                    (!simplified_mode_processing_msg || (cmd.sa >= `RDBM_MODE_DATA_LO && wcnt == 6'h00));

  ////////////////////////////////////////////////////////////////////////
  // Completion updates
  always_comb begin
    mask    = ((16'h0001 << cw[`RDBM_CW_N_HI:`RDBM_CW_N_LO]) - 16'h0001) << 1;
    // Full on the message that turns the last counted bit on, not one later
    c2_full = ((w4 + `RDBM_HDR_WORDS) & mask) == mask;
    c1_full = ({1'b0, dptr} + {1'b0, `RDBM_MSG_STRIDE}) >
              ({1'b0, w2} + {1'b0, `RDBM_CIRC_UNIT << cw[`RDBM_CW_N_HI:`RDBM_CW_N_LO]});
    upd2 = 1'b0;
    upd3 = 1'b0;
    upd4 = 1'b0;
    nw2  = w2 + `RDBM_MSG_STRIDE;
    nw3  = dptr;
    nw4  = (w4 & ~mask) | ((w4 + `RDBM_HDR_WORDS) & mask);
    if (!simplified_mode_processing_msg && endr.ok) begin
      case (bmode)
        rdbm_pkg::BM_INDEX: begin
          upd3 = w3 != 16'h0000 && !use_bc;
          nw3  = w3 - 16'h0001;
          upd2 = upd3 && w3 != 16'h0001;
        end
        rdbm_pkg::BM_CIRC1: begin
          upd3 = 1'b1;
          nw3  = c1_full ? w2 : dptr;
        end
        rdbm_pkg::BM_CIRC2: begin
          upd3 = 1'b1;
          upd4 = 1'b1;
          nw3  = c2_full ? w2 : dptr;
        end
        default: upd2 = 1'b0;
      endcase
    end
    toggle = !simplified_mode_processing_msg && bmode == rdbm_pkg::BM_PINGPONG && endr.ok && !cmd.bcast &&
             !(endr.busy && cfg_r[`RDBM_CFG_NT_BUSY]) && !(endr.illegal && cfg_r[`RDBM_CFG_NT_ILL]);
    ncw = cw | (16'h0001 << `RDBM_CW_ACC) | ({15'h0000, cmd.bcast} << `RDBM_CW_BRX);
    ncw[`RDBM_CW_PPSEL] = cw[`RDBM_CW_PPSEL] ^ toggle;
    ixz   = upd3 && bmode == rdbm_pkg::BM_INDEX && w3 == 16'h0001;
    cdone = upd3 && ((bmode == rdbm_pkg::BM_CIRC1 && c1_full) || (bmode == rdbm_pkg::BM_CIRC2 && c2_full));
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-state memory access
  always_comb begin
    st_mem  = 1'b1;
    st_we   = 1'b1;
    st_skip = 1'b0;
    st_addr = desc;
    st_wd   = 16'h0000;
    case (state)
      rdbm_pkg::S_CW:  st_we = 1'b0;
      rdbm_pkg::S_W2: begin st_we = 1'b0; st_addr = desc + 16'h0001; end
      rdbm_pkg::S_W3: begin st_we = 1'b0; st_addr = desc + 16'h0002; end
      rdbm_pkg::S_W4: begin st_we = 1'b0; st_addr = desc + 16'h0003; end
      rdbm_pkg::S_DWR: begin st_addr = dptr; st_wd = rxw; end
      rdbm_pkg::S_TRD: begin st_we = 1'b0; st_addr = dptr; end
      rdbm_pkg::S_MIW: begin st_addr = info; st_wd = endr.message_info_word; end
      rdbm_pkg::S_TTW: begin st_addr = info + 16'h0001; st_wd = endr.time_tag_word; end
      rdbm_pkg::S_U2: begin st_addr = desc + 16'h0001; st_wd = nw2; st_skip = !upd2; end
      rdbm_pkg::S_U3: begin st_addr = desc + 16'h0002; st_wd = nw3; st_skip = !upd3; end
      rdbm_pkg::S_U4: begin st_addr = desc + 16'h0003; st_wd = nw4; st_skip = !upd4; end
      rdbm_pkg::S_UCW: st_wd = ncw;
      default: st_mem = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Message sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= rdbm_pkg::S_IDLE;
      cmd          <= '0;
      endr         <= '0;
      desc         <= 16'h0000;
      cw           <= 16'h0000;
      w2           <= 16'h0000;
      w3           <= 16'h0000;
      w4           <= 16'h0000;
      dptr         <= 16'h0000;
      info         <= 16'h0000;
      rxw          <= 16'h0000;
      wcnt         <= 6'h00;
      mem_o        <= '0;
      desc_ready_o <= 1'b0;
      busy_o       <= 1'b0;
      word_ready_o <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_word_o    <= 16'h0000;
      done_o       <= 1'b0;
      evt_o        <= '0;
    end else begin
      desc_ready_o <= 1'b0;
      tx_valid_o   <= 1'b0;
      done_o       <= 1'b0;
      evt_o        <= '0;
      if (st_mem) begin
        if (mem_o.req) begin
          if (mem_ack_i) begin
            mem_o.req <= 1'b0;
            case (state)
              rdbm_pkg::S_CW:  begin cw <= mem_rdata_i; state <= rdbm_pkg::S_W2; end
              rdbm_pkg::S_W2:  begin w2 <= mem_rdata_i; state <= rdbm_pkg::S_W3; end
              rdbm_pkg::S_W3:  begin w3 <= mem_rdata_i; state <= rdbm_pkg::S_W4; end
              rdbm_pkg::S_W4:  begin w4 <= mem_rdata_i; state <= rdbm_pkg::S_DEC; end
              rdbm_pkg::S_DWR, rdbm_pkg::S_TRD: begin
                tx_word_o    <= mem_rdata_i;
                tx_valid_o   <= state == rdbm_pkg::S_TRD;
                dptr         <= dptr + 16'h0001;
                wcnt         <= wcnt + 6'h01;
                word_ready_o <= 1'b1;
                state        <= rdbm_pkg::S_XFER;
              end
              rdbm_pkg::S_MIW: state <= rdbm_pkg::S_TTW;
              rdbm_pkg::S_TTW: state <= rdbm_pkg::S_U2;
              rdbm_pkg::S_U2:  state <= rdbm_pkg::S_U3;
              rdbm_pkg::S_U3:  state <= rdbm_pkg::S_U4;
              rdbm_pkg::S_U4:  state <= rdbm_pkg::S_UCW;
              default: begin
                evt_o.accessed         <= cw[`RDBM_CW_IWA];
                evt_o.bcast_rx         <= cmd.bcast & cw[`RDBM_CW_IBR];
                evt_o.index_zero_event <= ixz & cw[`RDBM_CW_IXZ];
                evt_o.circ_done        <= cdone & cw[`RDBM_CW_IXZ];
                done_o                 <= 1'b1;
                state                  <= rdbm_pkg::S_IDLE;
              end
            endcase
          end
        end else if (st_skip) begin
          state <= (state == rdbm_pkg::S_U2) ? rdbm_pkg::S_U3 :
                   (state == rdbm_pkg::S_U3) ? rdbm_pkg::S_U4 : rdbm_pkg::S_UCW;
        end else begin
          mem_o <= '{req: 1'b1, we: st_we, addr: st_addr, wdata: st_wd};
        end
      end else begin
        case (state)
          rdbm_pkg::S_IDLE: begin
            if (cmd_valid_i) begin
              cmd   <= cmd_i;
              desc  <= next_desc;
              state <= rdbm_pkg::S_CW;
            end
          end
          rdbm_pkg::S_DEC: begin
            busy_o       <= cw[`RDBM_CW_BUSY];
            desc_ready_o <= 1'b1;
            word_ready_o <= 1'b1;
            dptr         <= data_a;
            info         <= info_a;
            wcnt         <= 6'h00;
            state        <= rdbm_pkg::S_XFER;
          end
          rdbm_pkg::S_XFER: begin
            // End wins over a word offered in the same cycle
            if (end_valid_i) begin
              endr         <= end_i;
              word_ready_o <= 1'b0;
              state        <= rdbm_pkg::S_MIW;
            end else if (!cmd.tx && rx_valid_i && store_ok) begin
              rxw          <= rx_word_i;
              word_ready_o <= 1'b0;
              state        <= rdbm_pkg::S_DWR;
            end else if (cmd.tx && tx_req_i) begin
              if (store_ok) begin
                word_ready_o <= 1'b0;
                state        <= rdbm_pkg::S_TRD;
              end else begin
                tx_word_o  <= 16'h0000;
                tx_valid_o <= 1'b1;
              end
            end
          end
          default: state <= rdbm_pkg::S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // block address
  a_desc_addr: assert property ((state == rdbm_pkg::S_IDLE && cmd_valid_i) |=> desc == $past(tbl_base) +
    {7'h00, $past(cmd_i.mode_cmd), $past(cmd_i.tx), $past(cmd_i.sa), 2'b00}) else $error("bad block address");

  a_busy_cw: assert property (desc_ready_o |-> busy_o == cw[`RDBM_CW_BUSY] && state == rdbm_pkg::S_XFER)
    else $error("busy not from control word");

  a_idx_dec: assert property ((state == rdbm_pkg::S_U3 && mem_o.req && !simplified_mode_processing_msg && bmode == rdbm_pkg::BM_INDEX)
    |-> mem_o.we && mem_o.wdata == w3 - 16'h0001 && w3 != 16'h0000) else $error("index count not decremented");

  a_idx_hold: assert property ((state == rdbm_pkg::S_U2 && bmode == rdbm_pkg::BM_INDEX && w3 <= 16'h0001 && !simplified_mode_processing_msg)
    |=> !mem_o.req && state == rdbm_pkg::S_U3) else $error("pointer moved at zero count");

  a_bc_notog: assert property ((state == rdbm_pkg::S_UCW && mem_o.req && cmd.bcast)
    |-> mem_o.wdata[`RDBM_CW_PPSEL] == cw[`RDBM_CW_PPSEL]) else $error("select toggled by broadcast");

  a_desc_order: assert property ($rose(state == rdbm_pkg::S_U2) |-> $past(state, 1) == rdbm_pkg::S_TTW)
    else $error("descriptor update before status words");

  a_simplified_mode_processing_info: assert property ((state == rdbm_pkg::S_MIW && mem_o.req && simplified_mode_processing_msg)
    |-> mem_o.we && mem_o.addr == desc + 16'h0001) else $error("mode info word misplaced");

  a_acc_flag: assert property ((state == rdbm_pkg::S_UCW && mem_o.req)
    |-> mem_o.wdata[`RDBM_CW_ACC] && mem_o.addr == desc) else $error("accessed flag not written");

endmodule // rdbm_engine

// ==== rdbm_cfg.svh ====
`ifndef RDBM_CFG_SVH
`define RDBM_CFG_SVH
`define RDBM_TBL_BASE_RST 16'h0400
`define RDBM_REG_BASE     6'h00
`define RDBM_REG_CFG      6'h01
`define RDBM_REG_STAT     6'h02
`define RDBM_CFG_SIMPLIFIED_MODE_PROCESSING     0
`define RDBM_CFG_NT_BUSY  1
`define RDBM_CFG_NT_ILL   2
`define RDBM_CW_IWA       15
`define RDBM_CW_IBR       14
`define RDBM_CW_IXZ       13
`define RDBM_CW_BUSY      12
`define RDBM_CW_MODE_HI   11
`define RDBM_CW_MODE_LO   10
`define RDBM_CW_N_HI      8
`define RDBM_CW_N_LO      6
`define RDBM_CW_ACC       4
`define RDBM_CW_BRX       3
`define RDBM_CW_PPSEL     2
`define RDBM_MSG_STRIDE   16'h0022
`define RDBM_HDR_WORDS    16'h0002
`define RDBM_CIRC_UNIT    16'h0020
`define RDBM_MODE_DATA_LO 5'h10
`endif

// ==== rdbm_pkg.sv ====
package rdbm_pkg;
  typedef enum logic [1:0] {BM_INDEX, BM_PINGPONG, BM_CIRC1, BM_CIRC2} rdbm_bufmode_t;
  typedef enum {S_IDLE, S_CW, S_W2, S_W3, S_W4, S_DEC, S_XFER, S_DWR, S_TRD,
                S_MIW, S_TTW, S_U2, S_U3, S_U4, S_UCW} rdbm_state_t;
  typedef struct packed {
    logic       mode_cmd;
    logic       tx;
    logic       bcast;
    logic [4:0] sa;
    logic [5:0] wc;
  } rdbm_cmd_t;
  typedef struct packed {
    logic        ok;
    logic        busy;
    logic        illegal;
    logic [15:0] message_info_word;
    logic [15:0] time_tag_word;
  } rdbm_end_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rdbm_mem_t;
  typedef struct packed {
    logic accessed;
    logic bcast_rx;
    logic index_zero_event;
    logic circ_done;
  } rdbm_evt_t;
endpackage

// ==== rdbm_ram.sv ====
`timescale 1ns/1ps
module rdbm_ram (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  rdbm_pkg::rdbm_mem_t mem_i,
  input  wire logic [3:0]     lat_i,
  output logic                ack_o,
  output logic [15:0]         rdata_o
);
  logic [15:0] mem [0:65535];
  logic [15:0] last_wr;
  logic [3:0]  cnt;
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 16'h0000;
    end
    ack_o = 1'b0;
    rdata_o = 16'h0000;
    last_wr = 16'h0000;
  end
  // Read data toggles outside ack so a stale value is never mistaken for an answer
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      cnt <= 4'h0;
    end else if (mem_i.req && !ack_o) begin
      if (cnt >= lat_i) begin
        ack_o <= 1'b1;
        cnt <= 4'h0;
        rdata_o <= mem[mem_i.addr];
        if (mem_i.we) begin
          mem[mem_i.addr] <= mem_i.wdata;
          last_wr <= mem_i.addr;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // rdbm_ram

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic                clk_i;
  logic                rst_i;
  logic [7:0]          adr;
  logic [31:0]         wdat;
  logic                we;
  logic                cyc;
  logic                stb;
  logic [31:0]         rdat;
  logic                ack;
  logic                cmd_v;
  rdbm_pkg::rdbm_cmd_t cmd;
  logic                desc_rdy;
  logic                busy;
  logic                wrdy;
  logic                rx_v;
  logic [15:0]         rx_w;
  logic                end_v;
  rdbm_pkg::rdbm_end_t end_d;
  logic                done;
  rdbm_pkg::rdbm_mem_t mem;
  logic                mack;
  logic [15:0]         mrd;
  rdbm_pkg::rdbm_evt_t evt;
  rdbm_pkg::rdbm_evt_t ev;
  logic                busy_seen;
  logic                tx_r;
  logic                txv;
  logic [15:0]         txw;
  logic [15:0]         tx_seen;
  logic [3:0]          lat;
  logic [31:0]         q;
  int                  bad_count;
  int                  checks_done;
  ////////////////////////////////////////////////////////////////
  rdbm_engine uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .cmd_valid_i(cmd_v),
    .cmd_i(cmd), .desc_ready_o(desc_rdy), .busy_o(busy), .word_ready_o(wrdy), .rx_valid_i(rx_v),
    .rx_word_i(rx_w), .tx_req_i(tx_r), .tx_valid_o(txv), .tx_word_o(txw), .end_valid_i(end_v), .end_i(end_d),
    .done_o(done), .mem_o(mem), .mem_ack_i(mack), .mem_rdata_i(mrd), .evt_o(evt));
  rdbm_ram ram (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem), .lat_i(lat), .ack_o(mack), .rdata_o(mrd));
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Outputs are looked at on the falling edge, where they have settled
  // Selector: 0 descriptor ready, 1 word ready, other done
  task automatic wt(input int s);
    int   k;
    logic v;
    k = 0;
    v = 1'b0;
    while (v !== 1'b1 && k < 500) begin
      @(negedge clk_i);
      k++;
      case (s)
        0:       v = desc_rdy;
        1:       v = wrdy;
        default: v = done;
      endcase
    end
    if (v !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  // Request held until the edge that samples ack high; data taken at that edge
  task automatic wbt(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 500);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  function automatic logic [31:0] m(input logic [15:0] a);
    return {16'h0000, ram.mem[a]};
  endfunction
  function automatic rdbm_pkg::rdbm_cmd_t rc(input logic md, input logic bc, input logic [4:0] s,
                                              input logic [5:0] w);
    return {md, 1'b0, bc, s, w};
  endfunction
  task automatic desc(input logic [15:0] a, input logic [15:0] w0, w1, w2, w3);
    ram.mem[a] = w0;
    ram.mem[a + 16'h1] = w1;
    ram.mem[a + 16'h2] = w2;
    ram.mem[a + 16'h3] = w3;
  endtask
  // One message: n data words received or transmitted, then the end with info 5a5a and time tag 0707
  task automatic msg(input rdbm_pkg::rdbm_cmd_t c, input int n, input logic bz);
    @(posedge clk_i);
    cmd_v <= 1'b1;
    cmd <= c;
    @(posedge clk_i);
    cmd_v <= 1'b0;
    wt(0);
    busy_seen = busy;
    for (int i = 0; i <= n; i++) begin
      wt(1);
      // A fetched transmit word is offered in the cycle ready returns
      if (txv === 1'b1) begin
        tx_seen = txw;
      end
      @(posedge clk_i);
      if (i < n) begin
        if (c.tx) begin
          tx_r <= 1'b1;
        end else begin
          rx_v <= 1'b1;
          rx_w <= 16'hd000 + 16'(i);
        end
      end else begin
        end_v <= 1'b1;
        end_d <= {1'b1, bz, 1'b0, 16'h5a5a, 16'h0707};
      end
      @(posedge clk_i);
      rx_v <= 1'b0;
      tx_r <= 1'b0;
      end_v <= 1'b0;
    end
    wt(2);
    ev = evt;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic regs();
    wbt(8'h00, 1'b0, 32'h0, q);
    chk("table base", 32'h0400, q & 32'hffff);
    wbt(8'h08, 1'b1, 32'hffffffff, q);
    wbt(8'h08, 1'b0, 32'h0, q);
    chk("status", 32'h0, q);
    wbt(8'h0c, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic idx();
    desc(16'h040c, 16'ha000, 16'h1000, 16'h0002, 16'h2000);
    msg(rc(1'b0, 1'b0, 5'd3, 6'd2), 2, 1'b0);
    chk("index info", 32'h5a5a, m(16'h1000));
    chk("index tag", 32'h0707, m(16'h1001));
    chk("index data", 32'hd001, m(16'h1003));
    chk("index count", 32'h1, m(16'h040e));
    chk("index ptr", 32'h1022, m(16'h040d));
    chk("control flags", 32'ha010, m(16'h040c));
    chk("last write", 32'h040c, {16'h0, ram.last_wr});
    msg(rc(1'b0, 1'b0, 5'd3, 6'd1), 1, 1'b0);
    chk("stacked data", 32'hd000, m(16'h1024));
    chk("count zero", 32'h0, m(16'h040e));
    chk("ptr held", 32'h1022, m(16'h040d));
    chk("zero event", 32'h1, ev.index_zero_event);
    msg(rc(1'b0, 1'b1, 5'd3, 6'd1), 1, 1'b0);
    chk("bcast data", 32'hd000, m(16'h2002));
    chk("bcast ptr kept", 32'h1022, m(16'h040d));
    chk("bcast flag", 32'h8, m(16'h040c) & 32'h8);
  endtask
  task automatic pp();
    desc(16'h0414, 16'h0400, 16'h3000, 16'h3100, 16'h2400);
    msg(rc(1'b0, 1'b0, 5'd5, 6'd1), 1, 1'b0);
    chk("pp a info", 32'h5a5a, m(16'h3000));
    chk("pp a data", 32'hd000, m(16'h3002));
    chk("pp select set", 32'h4, m(16'h0414) & 32'h4);
    msg(rc(1'b0, 1'b0, 5'd5, 6'd1), 1, 1'b0);
    chk("pp b info", 32'h5a5a, m(16'h3100));
    chk("pp select clear", 32'h0, m(16'h0414) & 32'h4);
    msg(rc(1'b0, 1'b1, 5'd5, 6'd1), 1, 1'b0);
    chk("pp bcast", 32'hd000, m(16'h2402));
    ram.mem[16'h0414] = ram.mem[16'h0414] | 16'h1000;
    wbt(8'h04, 1'b1, 32'h2, q);
    msg(rc(1'b0, 1'b0, 5'd5, 6'd1), 1, 1'b1);
    chk("busy level", 32'h1, busy_seen);
    chk("pp select held", 32'h0, m(16'h0414) & 32'h4);
    wbt(8'h04, 1'b1, 32'h0, q);
  endtask
  // Slow memory here, so every handshake waits several cycles
  task automatic circ();
    lat <= 4'h3;
    desc(16'h041c, 16'h2c40, 16'h5000, 16'h5010, 16'h4000);
    msg(rc(1'b0, 1'b0, 5'd7, 6'd2), 2, 1'b0);
    chk("circ info", 32'h5a5a, m(16'h4000));
    chk("circ tag", 32'h0707, m(16'h4001));
    chk("circ data", 32'hd001, m(16'h5011));
    chk("circ done", 32'h1, ev.circ_done);
    chk("circ restart", 32'h5000, m(16'h041e));
    chk("circ info next", 32'h4002, m(16'h041f));
    desc(16'h0428, 16'h2800, 16'h7000, 16'h7004, 16'h0000);
    msg(rc(1'b0, 1'b0, 5'd10, 6'd1), 1, 1'b0);
    chk("circ1 info", 32'h5a5a, m(16'h7004));
    chk("circ1 data", 32'hd000, m(16'h7006));
    chk("circ1 wrap", 32'h7000, m(16'h042a));
    chk("circ1 done", 32'h1, ev.circ_done);
    lat <= 4'h0;
  endtask
  task automatic smode();
    wbt(8'h04, 1'b1, 32'h1, q);
    desc(16'h0544, 16'h8000, 16'h0, 16'h0, 16'h0);
    msg(rc(1'b1, 1'b0, 5'd17, 6'd1), 1, 1'b0);
    chk("mode event", 32'h1, ev.accessed);
    chk("mode info", 32'h5a5a, m(16'h0545));
    chk("mode tag", 32'h0707, m(16'h0546));
    chk("mode data", 32'hd000, m(16'h0547));
    desc(16'h0508, 16'h0, 16'h0, 16'h0, 16'h0);
    msg(rc(1'b1, 1'b0, 5'd2, 6'd1), 1, 1'b0);
    chk("low code data", 32'h0, m(16'h050b));
    wbt(8'h04, 1'b1, 32'h0, q);
  endtask
  task automatic txm();
    desc(16'h0484, 16'h0000, 16'h7100, 16'h0000, 16'h0000);
    ram.mem[16'h7102] = 16'hbeef;
    msg({1'b0, 1'b1, 1'b0, 5'd1, 6'd1}, 1, 1'b0);
    chk("tx word", 32'hbeef, {16'h0, tx_seen});
    chk("tx info", 32'h5a5a, m(16'h7100));
  endtask
  task automatic tbl();
    wbt(8'h00, 1'b1, 32'h0800, q);
    wbt(8'h00, 1'b0, 32'h0, q);
    chk("new base", 32'h0800, q & 32'hffff);
    desc(16'h080c, 16'h0, 16'h6000, 16'h0, 16'h0);
    msg(rc(1'b0, 1'b0, 5'd3, 6'd1), 1, 1'b0);
    chk("table switch", 32'h5a5a, m(16'h6000));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {adr, wdat, we, cyc, stb, cmd_v, cmd, rx_v, rx_w, end_v, end_d, tx_r} = '0;
    lat = 4'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    regs();
    idx();
    pp();
    circ();
    smode();
    txm();
    tbl();
    finish_test();
  end
endmodule // tb
